// ### ctp_load.sv
module ctp_load (
   input wire logic clk_i,
   input wire logic [7:0] cmp_i,
   output int rise_o [8]
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] last = 8'h00;
   // A filter load only sees edges; rising edges are counted per pin
   always @(posedge clk_i) begin
      for (int n = 0; n < 8; n++) begin
         if (cmp_i[n] === 1'b1 && last[n] !== 1'b1) rise_o[n] <= rise_o[n] + 1;
      end
      last <= cmp_i;
   end
endmodule

// ### ctp_pkg.sv
package ctp_pkg;
   localparam int unsigned NUM_CMP = 8;
   localparam logic [9:0] IDX_CONTROL = 10'h0E1;
   localparam logic [11:0] ADDR_CONTROL = {IDX_CONTROL, 2'h0};
   localparam logic [11:0] ADDR_RELOAD_LOW = 12'h388;
   localparam logic [11:0] ADDR_RELOAD_HIGH = 12'h38C;
   localparam logic [11:0] ADDR_COUNT = 12'h390;
   localparam logic [11:0] ADDR_IRQ_CTRL = 12'h394;
   localparam logic [11:0] ADDR_CMP_BASE = 12'h3A0;
   localparam logic [11:0] ADDR_OUT_LATCH = 12'h3C0;
   localparam int unsigned CLK_SEL_LSB = 0;
   localparam int unsigned OVF_FLAG_BIT = 3;
   localparam int unsigned T2PS_BIT = 7;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] CONTROL_WMASK = 8'h87;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] CMP_RESET = 16'h0000;
   localparam logic [7:0] PRESCALE_RESET = 8'h00;

   typedef struct packed {
      logic [15:0] count;
      logic [7:0] prescale;
      logic running;
   } ctp_timer_t;

   typedef struct packed {
      logic [7:0] control;
      logic [7:0] reload_low_byte;
      logic [7:0] reload_high_byte;
      logic irq_enable;
   } ctp_regs_t;
endpackage

// ### ctp_timer.sv
// The APB slave port is this design's own decision.
module ctp_timer (
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic IRQ_ACK_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   output logic IRQ_REQ_O,
   output logic [7:0] CMP_OUT_O,
   output logic [7:0] T2_PRESCALE_SEL_O
);
   ctp_pkg::ctp_timer_t tmr, next_tmr;
   ctp_pkg::ctp_regs_t regs, next_regs;
   logic [15:0] cmp [0:7];
   logic [15:0] next_cmp [0:7];
   logic [7:0] cmp_out, next_cmp_out;
   logic [31:0] prdata, next_prdata;
   logic pready, next_pready;
   logic pslverr, next_pslverr;
   logic irq_req, next_irq_req;
   logic [7:0] t2ps_sel, next_t2ps_sel;

   logic access;
   logic wr;
   logic wr_low;
   logic tick;
   logic overflow;
   logic [7:0] div_mask;
   logic [15:0] reload_value;
   logic [2:0] cmp_idx;
   logic cmp_hit;
   logic decoded;

   assign access = PSEL_I && PENABLE_I && !pready;
   assign wr = access && PWRITE_I;
   assign wr_low = wr && (PADDR_I == ctp_pkg::ADDR_RELOAD_LOW);
   assign reload_value = {regs.reload_high_byte, regs.reload_low_byte};
   assign cmp_idx = PADDR_I[4:2];
   assign cmp_hit = (PADDR_I[11:5] == ctp_pkg::ADDR_CMP_BASE[11:5]);
   // Prescaler mask: code n divides by 2^(n+1)
   assign div_mask = 8'((9'h002 << regs.control[2:0]) - 9'h001);
   assign tick = tmr.running && ((tmr.prescale & div_mask) == div_mask);
   assign overflow = tick && (tmr.count == 16'hFFFF);

   always_comb begin
      next_tmr = tmr;
      if (tmr.running) begin
         next_tmr.prescale = 8'(tmr.prescale + 8'h01);
      end
      if (tick) begin
         if (overflow) begin
            next_tmr.count = reload_value;
         end else begin
            next_tmr.count = 16'(tmr.count + 16'h0001);
         end
      end
      // Low byte write starts or restarts; it wins over a concurrent tick
      if (wr_low) begin
         next_tmr.running = 1'b1;
         next_tmr.prescale = ctp_pkg::PRESCALE_RESET;
         next_tmr.count = {regs.reload_high_byte, PWDATA_I[7:0]};
      end
   end

   always_comb begin
      next_regs = regs;
      if (wr) begin
         unique case (PADDR_I)
            ctp_pkg::ADDR_CONTROL: begin
               // Flag bit is not writable, so a control write cannot lose an overflow
               next_regs.control = (PWDATA_I[7:0] & ctp_pkg::CONTROL_WMASK)
                  | (regs.control & ~ctp_pkg::CONTROL_WMASK);
            end
            ctp_pkg::ADDR_RELOAD_LOW: begin
               next_regs.reload_low_byte = PWDATA_I[7:0];
            end
            ctp_pkg::ADDR_RELOAD_HIGH: begin
               next_regs.reload_high_byte = PWDATA_I[7:0];
            end
            ctp_pkg::ADDR_IRQ_CTRL: begin
               next_regs.irq_enable = PWDATA_I[0];
            end
            default: begin
            end
         endcase
      end
      // Flag is hardware owned; service clears it but a new overflow wins
      if (IRQ_ACK_I) begin
         next_regs.control[ctp_pkg::OVF_FLAG_BIT] = 1'b0;
      end
      if (overflow) begin
         next_regs.control[ctp_pkg::OVF_FLAG_BIT] = 1'b1;
      end
   end

   // Output latches follow match and overflow only; no bus write path exists
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_cmp
         logic cmp_wr;
         logic cmp_match;

         assign cmp_wr = wr && cmp_hit && (cmp_idx == 3'(g));
         assign cmp_match = tmr.running && (tmr.count == cmp[g]);

         always_comb begin
            next_cmp[g] = cmp[g];
            if (cmp_wr) begin
               next_cmp[g] = PWDATA_I[15:0];
            end
         end

         always_comb begin
            next_cmp_out[g] = cmp_out[g];
            if (overflow) begin
               next_cmp_out[g] = 1'b0;
            end
            // Overflow owns its tick; a compare equal to the reload goes high next cycle
            if (cmp_match && !overflow) begin
               next_cmp_out[g] = 1'b1;
            end
         end

         always_ff @(posedge CLK_I) begin
            if (!RESET_N_I) begin
               cmp[g] <= ctp_pkg::CMP_RESET;
               cmp_out[g] <= 1'b0;
            end else begin
               cmp[g] <= next_cmp[g];
               cmp_out[g] <= next_cmp_out[g];
            end
         end
      end
   endgenerate

   always_comb begin
      next_irq_req = regs.irq_enable && next_regs.control[ctp_pkg::OVF_FLAG_BIT];
   end

   // Bit 7 only routed out for timer 2; software keeps it zero for counting
   always_comb begin
      next_t2ps_sel = {7'h00, next_regs.control[ctp_pkg::T2PS_BIT]};
   end

   always_comb begin
      next_pready = access;
      next_pslverr = 1'b0;
      next_prdata = 32'h0000_0000;
      decoded = 1'b1;
      if (access) begin
         if (cmp_hit) begin
            next_prdata = {16'h0000, cmp[cmp_idx]};
         end else begin
            unique case (PADDR_I)
               ctp_pkg::ADDR_CONTROL: next_prdata = {24'h000000, regs.control};
               ctp_pkg::ADDR_RELOAD_LOW: next_prdata = {24'h000000, regs.reload_low_byte};
               ctp_pkg::ADDR_RELOAD_HIGH: next_prdata = {24'h000000, regs.reload_high_byte};
               ctp_pkg::ADDR_COUNT: next_prdata = {16'h0000, tmr.count};
               ctp_pkg::ADDR_IRQ_CTRL: next_prdata = {31'h00000000, regs.irq_enable};
               // Latches read back, writes are dropped
               ctp_pkg::ADDR_OUT_LATCH: next_prdata = {24'h000000, cmp_out};
               default: decoded = 1'b0;
            endcase
         end
         next_pslverr = !decoded;
         if (!PWRITE_I == 1'b0) begin
            next_prdata = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         tmr <= '{count: ctp_pkg::COUNT_RESET, prescale: ctp_pkg::PRESCALE_RESET,
                  running: 1'b0};
      end else begin
         tmr <= next_tmr;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         regs <= '{control: ctp_pkg::CONTROL_RESET, reload_low_byte: 8'h00,
                   reload_high_byte: 8'h00, irq_enable: 1'b0};
      end else begin
         regs <= next_regs;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         irq_req <= 1'b0;
      end else begin
         irq_req <= next_irq_req;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         t2ps_sel <= 8'h00;
      end else begin
         t2ps_sel <= next_t2ps_sel;
      end
   end

   assign PRDATA_O = prdata;
   assign PREADY_O = pready;
   assign PSLVERR_O = pslverr;
   assign IRQ_REQ_O = irq_req;
   assign CMP_OUT_O = cmp_out;
   assign T2_PRESCALE_SEL_O = t2ps_sel;
endmodule

// ### ctp_timer_sva.sv
module ctp_timer_sva (
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   input wire logic [7:0] CMP_OUT_O,
   input wire logic [7:0] T2_PRESCALE_SEL_O
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RESET_N_I);
   sequence s_taken;
      PSEL_I && PENABLE_I && !PREADY_O;
   endsequence
   sequence s_answer;
      PREADY_O ##1 !PREADY_O;
   endsequence
   a_one_wait: assert property (s_taken |=> s_answer)
      else $error("bad ready");
   a_idle_zero: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
      else $error("read data not zero");
   a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
      else $error("stray error");
   a_unmapped_err: assert property (s_taken ##0 (PADDR_I == 12'h3FC) |=> PSLVERR_O)
      else $error("unmapped not refused");
   a_latch_ok: assert property (s_taken ##0 (PWRITE_I && PADDR_I == 12'h3C0) |=> !PSLVERR_O)
      else $error("latch write refused");
   a_ctl_ok: assert property (s_taken ##0 (PADDR_I == 12'h384) |=> !PSLVERR_O)
      else $error("control refused");
   a_fall_together: assert property (|($past(CMP_OUT_O) & ~CMP_OUT_O) |-> CMP_OUT_O == 8'h00)
      else $error("outputs not cleared together");
   a_t2ps_upper: assert property (T2_PRESCALE_SEL_O[7:1] == 7'h00)
      else $error("select upper bits set");
   a_t2ps_follow: assert property (s_taken ##0 (PWRITE_I && PADDR_I == 12'h384) |=>
      T2_PRESCALE_SEL_O[0] == $past(PWDATA_I[7]))
      else $error("select bit not taken");
endmodule
bind ctp_timer ctp_timer_sva u_sva (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I),
   .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
   .PRDATA_O(PRDATA_O),
   .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .CMP_OUT_O(CMP_OUT_O),
   .T2_PRESCALE_SEL_O(T2_PRESCALE_SEL_O));

// ### test_compare_timer_pwm.sv
module test_compare_timer_pwm;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, ack = 0, pready, pslverr, irq, err;
   logic [11:0] paddr = 12'h000, a;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:0] cmp, t2ps;
   logic [31:0] mdl [logic [11:0]];
   int n_fail = 0, checks = 0, seed = 13, c0, c1, r0, r1, n;
   int rises [8];
   ctp_timer DUT (.CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .IRQ_ACK_I(ack), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_REQ_O(irq), .CMP_OUT_O(cmp),
      .T2_PRESCALE_SEL_O(t2ps));
   ctp_load u_load (.clk_i(clk), .cmp_i(cmp), .rise_o(rises));
   initial forever #12.5 clk = ~clk;
   task tally_and_finish;
      if (n_fail == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] x, input logic [31:0] d);
      @(posedge clk);
      paddr <= x;
      pwdata <= d;
      pwrite <= w;
      psel <= 1'b1;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20) n_fail++;
      psel <= 1'b0;
      penable <= 1'b0;
      // Model keeps only the bits a write really stores, except at 0x390 and 0x3C0 where it keeps bits the write drops
      if (w) mdl[x] = d & (x == 12'h384 ? 32'h87 : x == 12'h394 ? 32'h1 : x >= 12'h3A0 ? 32'hFFFF : 32'hFF);
   endtask
   task rdchk(input logic [11:0] x);
      apb(1'b0, x, 32'h0);
      chk(rd, mdl[x]);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 13; i++) begin
         a = (i < 5) ? 12'h384 + 12'(4 * i) : 12'h3A0 + 12'(4 * (i - 5));
         mdl[a] = 32'h0;
         rdchk(a);
      end
      repeat (40) @(posedge clk);
      rdchk(12'h390);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, 12'h3A0 + 12'(4 * i), $random(seed));
         rdchk(12'h3A0 + 12'(4 * i));
      end
      apb(1'b1, 12'h384, $random(seed));
      rdchk(12'h384);
      chk(32'(t2ps), {31'h0, mdl[12'h384][7]});
      apb(1'b0, 12'h3FC, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      for (int s = 0; s < 8; s++) begin
         apb(1'b1, 12'h384, 32'(s)); // Bit 7 kept low
         apb(1'b1, 12'h38C, 32'h0);
         apb(1'b1, 12'h388, 32'h0);
         apb(1'b0, 12'h390, 32'h0);
         c0 = rd;
         repeat (512) @(posedge clk);
         apb(1'b0, 12'h390, 32'h0);
         c1 = rd - c0 - (512 >> (s + 1));
         chk(32'(c1 >= 0 && c1 <= 3), 32'h1);
      end
      apb(1'b1, 12'h38C, 32'h12);
      apb(1'b1, 12'h388, 32'h34);
      apb(1'b0, 12'h390, 32'h0);
      chk(32'(rd - 32'h1234 <= 32'h1), 32'h1);
      apb(1'b1, 12'h384, 32'h0);
      apb(1'b1, 12'h3A0, 32'hFFF8);
      apb(1'b1, 12'h3A4, 32'h0);
      apb(1'b1, 12'h394, 32'h1);
      apb(1'b1, 12'h38C, 32'hFF);
      apb(1'b1, 12'h388, 32'hF0);
      r0 = rises[0];
      r1 = rises[1];
      repeat (200) @(posedge clk);
      chk(32'(rises[0] - r0 >= 5), 32'h1);
      chk(32'(rises[1]), 32'(r1));
      apb(1'b1, 12'h3C0, 32'hFF);
      chk(32'(cmp[1]), 32'h0);
      apb(1'b0, 12'h384, 32'h0);
      chk(rd, 32'h8);
      chk(32'(irq), 32'h1);
      // Wait for a fresh rise so the next overflow is far away when the ack lands
      for (n = 0; n < 100 && cmp[0] === 1'b1; n++) @(posedge clk);
      for (n = 0; n < 100 && cmp[0] !== 1'b1; n++) @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      repeat (3) @(posedge clk);
      chk(32'(irq), 32'h0);
      apb(1'b1, 12'h394, 32'h0);
      repeat (40) @(posedge clk);
      apb(1'b0, 12'h384, 32'h0);
      chk(rd, 32'h8);
      chk(32'(irq), 32'h0);
      tally_and_finish();
   end
   initial begin
      #1000000;
      n_fail++;
      tally_and_finish();
   end
endmodule
